// >>> logic/rx_core_end.sv
// Receive core end: word FIFOs, buffer read ports, status RAM and quarter-rate status clock.

////////////////////////////////////////////////////////////////////////////////
module rx_word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic                       sys_clk_in,
  input  wire logic                       rst_b_in,
  input  wire logic                       in_valid_in,
  output logic                            in_ready_out,
  input  wire logic [WIDTH-1:0]           in_data_in,
  output logic                            out_valid_out,
  input  wire logic                       out_ready_in,
  input  wire logic [$clog2(DEPTH)-1:0]   peek_off_in,
  output logic [WIDTH-1:0]                out_data_out,
  output logic [$clog2(DEPTH):0]          level_out
);
  localparam int PW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 4 || (1 << PW) != DEPTH || WIDTH < 1) begin
      $error("rx_word_fifo: DEPTH must be a power of two of at least 4");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wr_ptr_q;
  logic [PW:0]      wr_ptr_d;
  logic [PW:0]      rd_ptr_q;
  logic [PW:0]      rd_ptr_d;
  logic             push;
  logic             pop;

  always_comb begin
    level_out     = wr_ptr_q - rd_ptr_q;
    in_ready_out  = (level_out != (PW+1)'(DEPTH));
    out_valid_out = (level_out != '0);
    push          = in_valid_in && in_ready_out;
    pop           = out_valid_out && out_ready_in;
    wr_ptr_d      = wr_ptr_q + (PW+1)'(push);
    rd_ptr_d      = rd_ptr_q + (PW+1)'(pop);
    // A peek past the filled words returns stale storage; the reader must mind the level.
    out_data_out  = mem[rd_ptr_q[PW-1:0] + peek_off_in];
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem[wr_ptr_q[PW-1:0]] <= in_data_in;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// R1: Byte valid bit n qualifies byte n.
// R2: Flag words carrying a port identifier.
// R3: Mark the word that starts a packet.
// R4: Mark the word that ends a packet.
// R5: Mark words flagged as erroneous.
// R6: Empty flag kind chosen per buffer.
// R7: User supplies end-of-packet halt control.
// R8: Port selector is status RAM address.
// R9: User supplies two-bit status per port.
// R10: Send enable puts stored status on link.
// R11: Status RAM written only with enable.
// R12: Status RAM written on user write clock.
// R13: User keeps delay off in dynamic mode.
// R14: Delay enable inserts or bypasses delay.
// R15: Delay select limited to zero through six.
// R16: Status clock is source clock over four.
// R17: Read ports run on user read clocks.
// R18: Status RAM holds 256 two-bit entries.
module rx_core_end
  import pkt_rx_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic                    sys_clk_in,
  input  wire logic                    rst_b_in,
  pkt_rx_if.core                       link,
  input  wire logic [NUM_BUF-1:0]      fill_valid_in,
  output logic [NUM_BUF-1:0]           fill_ready_out,
  input  wire rx_word_s [NUM_BUF-1:0]  fill_word_in,
  input  wire logic [NUM_BUF-1:0]      empty_flag_kind_sel_in,
  input  wire logic                    rx_source_clock_in,
  output logic [STAT_W-1:0]            flow_stat_word_out,
  output logic                         flow_stat_clk_out
);
  localparam int PW = $clog2(DEPTH);
  localparam int QTR_LVL = DEPTH / 4;
  localparam int SYNC_W = NUM_BUF * (ADDR_W + 3) + PORT_W + STAT_W + DLY_W + 5;

  initial begin
    if (DEPTH < (1 << ADDR_W)) begin
      $error("rx_core_end: DEPTH must cover every read address");
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Every pin from the user logic passes two flip-flops before use.
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [SYNC_W-1:0] pins_raw;

  always_comb begin
    pins_raw = {link.rd_clk, link.rd_en, link.rd_addr, link.halt_at_pkt_end_ctl,
                link.flow_stat_port_sel, link.flow_stat_value, link.flow_stat_we,
                link.flow_stat_wr_clk, link.flow_stat_send_en, link.rx_clk_dly_en,
                link.rx_clk_dly_sel, rx_source_clock_in};
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  logic [NUM_BUF-1:0]             rd_clk_s;
  logic [NUM_BUF-1:0]             rd_en_s;
  logic [NUM_BUF-1:0][ADDR_W-1:0] rd_addr_s;
  logic [NUM_BUF-1:0]             halt_s;
  logic [PORT_W-1:0]              port_s;
  logic [STAT_W-1:0]              value_s;
  logic                           we_s;
  logic                           wr_clk_s;
  logic                           send_en_s;
  logic                           dly_en_s;
  logic [DLY_W-1:0]               dly_sel_s;
  logic                           src_s;

  always_comb begin
    {rd_clk_s, rd_en_s, rd_addr_s, halt_s, port_s, value_s, we_s, wr_clk_s,
     send_en_s, dly_en_s, dly_sel_s, src_s} = sync2_q;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Buffer read ports.
  for (genvar b = 0; b < NUM_BUF; b++) begin : g_buf
    logic          out_valid;
    rx_word_s      head_word;
    logic [PW:0]   level;
    logic          pop;
    logic          rd_clk_prev_q;
    logic          hold_q;
    logic          hold_d;
    rx_word_s      word_q;
    rx_word_s      word_d;
    logic          empty_q;
    logic          empty_d;

    rx_word_fifo #(
      .WIDTH (ENTRY_W),
      .DEPTH (DEPTH)
    ) u_fifo (
      .sys_clk_in    (sys_clk_in),
      .rst_b_in      (rst_b_in),
      .in_valid_in   (fill_valid_in[b]),
      .in_ready_out  (fill_ready_out[b]),
      .in_data_in    (fill_word_in[b]),
      .out_valid_out (out_valid),
      .out_ready_in  (pop),
      .peek_off_in   (PW'(rd_addr_s[b])),
      .out_data_out  (head_word),
      .level_out     (level)
    );

    always_comb begin
      pop    = rd_clk_s[b] && !rd_clk_prev_q && rd_en_s[b] && !hold_q && out_valid; // R17
      hold_d = hold_q;
      // Once a packet's last word leaves with halt at packet end set, reads pause until the enable drops.
      if (pop && head_word.last && halt_s[b]) begin
        hold_d = 1'h1; // R7
      end else if (!rd_en_s[b]) begin
        hold_d = 1'h0;
      end
      word_d = pop ? head_word : word_q; // R1 R2 R3 R4 R5
      if (empty_flag_kind_sel_in[b] == KIND_TRUE_EMPTY) begin
        empty_d = (level == '0); // R6
      end else begin
        empty_d = (level <= (PW+1)'(QTR_LVL - 1)); // R6
      end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        rd_clk_prev_q <= 1'h0;
        hold_q        <= 1'h0;
        word_q        <= '0;
        empty_q       <= 1'h1;
      end else begin
        rd_clk_prev_q <= rd_clk_s[b];
        hold_q        <= hold_d;
        word_q        <= word_d;
        empty_q       <= empty_d;
      end
    end

    always_comb begin
      link.rd_word[b]     = word_q.data;
      link.byte_valid[b]  = word_q.be; // R1
      link.portid_flag[b] = word_q.portid; // R2
      link.pkt_first[b]   = word_q.first; // R3
      link.pkt_last[b]    = word_q.last; // R4
      link.word_bad[b]    = word_q.bad; // R5
      link.empty_flag[b]  = empty_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flow-control status RAM, written on the user's write clock edges.
  logic [STAT_W-1:0] stat_ram [PORT_CNT]; // R18
  logic              wr_clk_prev_q;
  logic              ram_we;

  always_comb begin
    ram_we = wr_clk_s && !wr_clk_prev_q && we_s; // R11 R12
  end

  always_ff @(posedge sys_clk_in) begin
    if (ram_we) begin
      stat_ram[port_s] <= value_s; // R8 R9
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Source clock delay line and quarter-rate status clock.
  logic [DLY_MAX:0]  tap_q;
  logic              sel_clk;
  logic              sel_prev_q;
  logic              div_q;
  logic              div_d;
  logic              qtr_q;
  logic              qtr_d;
  logic [PORT_W-1:0] scan_q;
  logic [PORT_W-1:0] scan_d;
  logic [STAT_W-1:0] stat_q;
  logic [STAT_W-1:0] stat_d;

  always_comb begin
    // Each tap is one system clock of delay, so the step is far coarser than a real line.
    sel_clk = dly_en_s ? tap_q[clamp_dly(dly_sel_s)] : src_s; // R14 R15
    div_d   = div_q;
    qtr_d   = qtr_q;
    scan_d  = scan_q;
    stat_d  = stat_q;
    if (sel_clk && !sel_prev_q) begin
      div_d = !div_q;
      if (div_q) begin
        qtr_d = !qtr_q; // R16
      end
    end
    if (qtr_d && !qtr_q) begin
      scan_d = scan_q + PORT_W'(1);
      stat_d = send_en_s ? stat_ram[scan_q] : STAT_IDLE; // R10
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tap_q         <= '0;
      sel_prev_q    <= 1'h0;
      wr_clk_prev_q <= 1'h0;
      div_q         <= 1'h0;
      qtr_q         <= 1'h0;
      scan_q        <= '0;
      stat_q        <= STAT_IDLE;
    end else begin
      tap_q         <= {tap_q[DLY_MAX-1:0], src_s};
      sel_prev_q    <= sel_clk;
      wr_clk_prev_q <= wr_clk_s;
      div_q         <= div_d;
      qtr_q         <= qtr_d;
      scan_q        <= scan_d;
      stat_q        <= stat_d;
    end
  end

  always_comb begin
    link.rx_status_clk = qtr_q; // R16
    flow_stat_clk_out  = qtr_q;
    flow_stat_word_out = stat_q;
  end
endmodule

// >>> shared/pkt_rx_pkg.sv
// Shared constants, types and helpers for the receive buffer read and status port.
package pkt_rx_pkg;
  localparam int NUM_BUF    = 2;
  localparam int BUF_FIRST  = 2;
  localparam int WORD_W     = 32;
  localparam int BE_W       = 4;
  localparam int ADDR_W     = 3;
  localparam int FIFO_DEPTH = 8;
  localparam int PORT_W     = 8;
  localparam int PORT_CNT   = 256;
  localparam int STAT_W     = 2;
  localparam int DLY_W      = 3;
  localparam int DLY_MAX    = 6;
  localparam int SRC_DIV    = 4;
  localparam int SYNC_LAT   = 2;
  localparam int RD_WAIT    = 4;
  localparam logic [STAT_W-1:0] STAT_IDLE     = 2'h0;
  localparam logic              KIND_TRUE_EMPTY = 1'h0;

  typedef struct packed {
    logic              portid;
    logic              first;
    logic              last;
    logic              bad;
    logic [BE_W-1:0]   be;
    logic [WORD_W-1:0] data;
  } rx_word_s;

  localparam int ENTRY_W = $bits(rx_word_s);

  // Limits an out-of-range delay tap to the last legal one.
  function automatic logic [DLY_W-1:0] clamp_dly(input logic [DLY_W-1:0] sel);
    clamp_dly = (sel > DLY_W'(DLY_MAX)) ? DLY_W'(DLY_MAX) : sel;
  endfunction
endpackage

// >>> shared/pkt_rx_if.sv
// Carrier between the receive core end and the user logic end.
interface pkt_rx_if
  import pkt_rx_pkg::*;
();
  logic [NUM_BUF-1:0]             rd_clk;
  logic [NUM_BUF-1:0]             rd_en;
  logic [NUM_BUF-1:0][ADDR_W-1:0] rd_addr;
  logic [NUM_BUF-1:0]             halt_at_pkt_end_ctl;
  logic [NUM_BUF-1:0][WORD_W-1:0] rd_word;
  logic [NUM_BUF-1:0][BE_W-1:0]   byte_valid;
  logic [NUM_BUF-1:0]             portid_flag;
  logic [NUM_BUF-1:0]             pkt_first;
  logic [NUM_BUF-1:0]             pkt_last;
  logic [NUM_BUF-1:0]             word_bad;
  logic [NUM_BUF-1:0]             empty_flag;
  logic [PORT_W-1:0]              flow_stat_port_sel;
  logic [STAT_W-1:0]              flow_stat_value;
  logic                           flow_stat_we;
  logic                           flow_stat_wr_clk;
  logic                           flow_stat_send_en;
  logic                           rx_clk_dly_en;
  logic [DLY_W-1:0]               rx_clk_dly_sel;
  logic                           rx_status_clk;

  modport core (
    input  rd_clk, rd_en, rd_addr, halt_at_pkt_end_ctl,
    output rd_word, byte_valid, portid_flag, pkt_first, pkt_last, word_bad, empty_flag,
    input  flow_stat_port_sel, flow_stat_value, flow_stat_we, flow_stat_wr_clk,
    input  flow_stat_send_en, rx_clk_dly_en, rx_clk_dly_sel,
    output rx_status_clk
  );

  modport user (
    output rd_clk, rd_en, rd_addr, halt_at_pkt_end_ctl,
    input  rd_word, byte_valid, portid_flag, pkt_first, pkt_last, word_bad, empty_flag,
    output flow_stat_port_sel, flow_stat_value, flow_stat_we, flow_stat_wr_clk,
    output flow_stat_send_en, rx_clk_dly_en, rx_clk_dly_sel,
    input  rx_status_clk
  );
endinterface

// >>> logic/rx_user_end.sv
// User logic end: drives buffer reads and status RAM writes through the carrier.

////////////////////////////////////////////////////////////////////////////////
module rx_user_end
  import pkt_rx_pkg::*;
(
  input  wire logic                    sys_clk_in,
  input  wire logic                    rst_b_in,
  pkt_rx_if.user                       link,
  input  wire logic                    rd_req_in,
  input  wire logic                    rd_buf_in,
  input  wire logic [ADDR_W-1:0]       rd_addr_in,
  input  wire logic [NUM_BUF-1:0]      halt_at_pkt_end_in,
  input  wire logic                    stat_req_in,
  input  wire logic [PORT_W-1:0]       stat_port_in,
  input  wire logic [STAT_W-1:0]       stat_value_in,
  input  wire logic                    send_en_in,
  input  wire logic                    static_mode_in,
  input  wire logic                    dly_en_in,
  input  wire logic [DLY_W-1:0]        dly_sel_in,
  output logic                         busy_out,
  output logic                         rd_done_out,
  output rx_word_s                     rd_word_out,
  output logic [NUM_BUF-1:0]           empty_out
);
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_SETUP = 2'h1,
    ST_HIGH  = 2'h3,
    ST_WAIT  = 2'h2
  } op_state_e;

  localparam logic [2:0] WAIT_LAST = 3'(RD_WAIT - 1);

  op_state_e          state_q;
  op_state_e          state_d;
  logic               is_rd_q;
  logic               is_rd_d;
  logic               buf_q;
  logic               buf_d;
  logic [ADDR_W-1:0]  addr_q;
  logic [ADDR_W-1:0]  addr_d;
  logic [PORT_W-1:0]  port_q;
  logic [PORT_W-1:0]  port_d;
  logic [STAT_W-1:0]  value_q;
  logic [STAT_W-1:0]  value_d;
  logic [2:0]         wait_q;
  logic [2:0]         wait_d;
  logic               clk_hi_q;
  logic               clk_hi_d;
  logic               done_q;
  logic               done_d;
  rx_word_s           word_q;
  rx_word_s           word_d;
  logic               send_q;
  logic               dly_en_q;
  logic [DLY_W-1:0]   dly_sel_q;
  logic [NUM_BUF-1:0] empty_q;
  logic [NUM_BUF-1:0] halt_q;

  always_comb begin
    state_d  = state_q;
    is_rd_d  = is_rd_q;
    buf_d    = buf_q;
    addr_d   = addr_q;
    port_d   = port_q;
    value_d  = value_q;
    wait_d   = wait_q;
    clk_hi_d = 1'h0;
    done_d   = 1'h0;
    word_d   = word_q;
    unique case (state_q)
      ST_IDLE: begin
        // A read request wins when both arrive together.
        if (rd_req_in) begin
          is_rd_d = 1'h1;
          buf_d   = rd_buf_in;
          addr_d  = rd_addr_in;
          state_d = ST_SETUP;
        end else if (stat_req_in) begin
          is_rd_d = 1'h0;
          port_d  = stat_port_in; // R8
          value_d = stat_value_in; // R9
          state_d = ST_SETUP;
        end
      end
      ST_SETUP: begin
        clk_hi_d = 1'h1; // R12 R17
        state_d  = ST_HIGH;
      end
      ST_HIGH: begin
        wait_d  = '0;
        state_d = ST_WAIT;
      end
      ST_WAIT: begin
        wait_d = wait_q + 3'h1;
        if (wait_q == WAIT_LAST) begin
          done_d  = 1'h1;
          state_d = ST_IDLE;
          if (is_rd_q) begin
            word_d = '{portid: link.portid_flag[buf_q], first: link.pkt_first[buf_q],
                       last: link.pkt_last[buf_q], bad: link.word_bad[buf_q],
                       be: link.byte_valid[buf_q], data: link.rd_word[buf_q]};
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q   <= ST_IDLE;
      is_rd_q   <= 1'h0;
      buf_q     <= 1'h0;
      addr_q    <= '0;
      port_q    <= '0;
      value_q   <= '0;
      wait_q    <= '0;
      clk_hi_q  <= 1'h0;
      done_q    <= 1'h0;
      word_q    <= '0;
      send_q    <= 1'h0;
      dly_en_q  <= 1'h0;
      dly_sel_q <= '0;
      empty_q   <= '1;
      halt_q    <= '0;
    end else begin
      state_q   <= state_d;
      is_rd_q   <= is_rd_d;
      buf_q     <= buf_d;
      addr_q    <= addr_d;
      port_q    <= port_d;
      value_q   <= value_d;
      wait_q    <= wait_d;
      clk_hi_q  <= clk_hi_d;
      done_q    <= done_d;
      word_q    <= word_d;
      send_q    <= send_en_in;
      dly_en_q  <= dly_en_in && static_mode_in; // R13
      dly_sel_q <= clamp_dly(dly_sel_in); // R15
      empty_q   <= link.empty_flag;
      halt_q    <= halt_at_pkt_end_in; // R7
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Carrier outputs are held while the strobes are high so the far end samples them settled.
  logic op_live;

  always_comb begin
    op_live = (state_q != ST_IDLE);
    for (int i = 0; i < NUM_BUF; i++) begin
      link.rd_clk[i]  = clk_hi_q && is_rd_q && (buf_q == 1'(i)); // R17
      link.rd_en[i]   = op_live && is_rd_q && (buf_q == 1'(i)); // R17
      link.rd_addr[i] = addr_q;
    end
    link.halt_at_pkt_end_ctl = halt_q;
    link.flow_stat_port_sel  = port_q; // R8
    link.flow_stat_value     = value_q; // R9
    link.flow_stat_we        = op_live && !is_rd_q; // R11
    link.flow_stat_wr_clk    = clk_hi_q && !is_rd_q; // R12
    link.flow_stat_send_en   = send_q; // R10
    link.rx_clk_dly_en       = dly_en_q; // R13
    link.rx_clk_dly_sel      = dly_sel_q; // R15
    busy_out                 = op_live;
    rd_done_out              = done_q;
    rd_word_out              = word_q;
    empty_out                = empty_q;
  end
endmodule

// >>> sim/rx_link_properties.sv
// Concurrent checks on the carrier between the receive core end and the user end.
module rx_link_properties
  import pkt_rx_pkg::*;
(
  input wire logic                           sys_clk_in,
  input wire logic                           rst_b_in,
  input wire logic [NUM_BUF-1:0]             rd_clk,
  input wire logic [NUM_BUF-1:0]             rd_en,
  input wire logic [NUM_BUF-1:0][ADDR_W-1:0] rd_addr,
  input wire logic [NUM_BUF-1:0][WORD_W-1:0] rd_word,
  input wire logic [NUM_BUF-1:0][BE_W-1:0]   byte_valid,
  input wire logic [NUM_BUF-1:0]             pkt_last,
  input wire logic                           flow_stat_we,
  input wire logic                           flow_stat_wr_clk,
  input wire logic [DLY_W-1:0]               rx_clk_dly_sel,
  input wire logic                           rx_status_clk
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  ////////////////////////////////////////////////////////////////////////////////
  AST_RD_STROBE_PULSE: assert property ($rose(rd_clk[0]) |=> !rd_clk[0])
    else $error("read strobe held longer than one cycle");
  AST_RD_EN_SETUP: assert property (
    $rose(rd_clk[1]) |-> $past(rd_en[1]) && $stable(rd_addr[1]))
    else $error("read enable or address not set up before strobe");
  AST_RD_EN_HOLD: assert property (
    $rose(rd_clk[0]) |-> rd_en[0] [*5] ##1 !rd_en[0])
    else $error("read enable not held for the whole read");
  // Buffer 0 word, byte valid and last flag may only move as the answer to a strobe; anything else corrupts the user view.
  AST_WORD_STANDS: assert property (
    $changed({rd_word[0], byte_valid[0], pkt_last[0]}) |-> $past(rd_clk[0], 3))
    else $error("read word changed without a read");
  AST_STAT_WE_AT_WRCLK: assert property (
    $rose(flow_stat_wr_clk) |-> flow_stat_we && $past(flow_stat_we))
    else $error("status write clock without write enable");
  AST_STAT_WRCLK_PULSE: assert property (flow_stat_wr_clk |=> !flow_stat_wr_clk)
    else $error("status write clock held high");
  AST_STAT_WE_HOLD: assert property (
    $rose(flow_stat_wr_clk) |-> flow_stat_we [*5] ##1 !flow_stat_we)
    else $error("status write enable not released in time");
  AST_DLY_SEL_LEGAL: assert property (rx_clk_dly_sel <= 3'h6)
    else $error("delay select out of range");
  AST_STATUS_CLK_HIGH: assert property ($rose(rx_status_clk) |-> rx_status_clk [*2])
    else $error("status clock high phase too short");
endmodule

// >>> sim/pkt_rx_fifo_read_and_status_port_tb.sv
// Self-checking bench joining the receive core end and the user end.
module pkt_rx_fifo_read_and_status_port_tb
  import pkt_rx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic                   sys_clk;
  logic                   rst_b;
  logic [NUM_BUF-1:0]     fill_valid;
  logic [NUM_BUF-1:0]     fill_ready_out;
  rx_word_s [NUM_BUF-1:0] fill_word;
  logic [NUM_BUF-1:0]     kind_sel;
  logic [NUM_BUF-1:0]     halt;
  logic                   busy;
  logic [1:0]             src_cnt;
  logic [STAT_W-1:0]      flow_stat_word_out;
  logic                   flow_stat_clk_out;
  logic                   rd_req;
  logic                   rd_buf;
  logic [ADDR_W-1:0]      rd_addr;
  logic                   stat_req;
  logic [PORT_W-1:0]      stat_port;
  logic [STAT_W-1:0]      stat_val;
  logic                   send_en;
  logic                   static_mode;
  logic                   dly_en;
  logic [DLY_W-1:0]       dly_sel;
  logic                   rd_done_out;
  rx_word_s               rd_word_out;
  logic [NUM_BUF-1:0]     empty_out;
  int                     n_fail;
  int                     checks_done;

  pkt_rx_if link ();

  rx_core_end #(.DEPTH(FIFO_DEPTH)) i_rx_core_end (
    .sys_clk_in(sys_clk), .rst_b_in(rst_b), .link(link.core),
    .fill_valid_in(fill_valid), .fill_ready_out(fill_ready_out), .fill_word_in(fill_word),
    .empty_flag_kind_sel_in(kind_sel), .rx_source_clock_in(src_cnt[1]),
    .flow_stat_word_out(flow_stat_word_out), .flow_stat_clk_out(flow_stat_clk_out));

  rx_user_end i_rx_user_end (
    .sys_clk_in(sys_clk), .rst_b_in(rst_b), .link(link.user),
    .rd_req_in(rd_req), .rd_buf_in(rd_buf), .rd_addr_in(rd_addr), .halt_at_pkt_end_in(halt),
    .stat_req_in(stat_req), .stat_port_in(stat_port), .stat_value_in(stat_val),
    .send_en_in(send_en), .static_mode_in(static_mode), .dly_en_in(dly_en),
    .dly_sel_in(dly_sel), .busy_out(busy), .rd_done_out(rd_done_out),
    .rd_word_out(rd_word_out), .empty_out(empty_out));

  rx_link_properties i_rx_link_properties (
    .sys_clk_in(sys_clk), .rst_b_in(rst_b), .rd_clk(link.rd_clk), .rd_en(link.rd_en),
    .rd_addr(link.rd_addr), .rd_word(link.rd_word), .byte_valid(link.byte_valid),
    .pkt_last(link.pkt_last), .flow_stat_we(link.flow_stat_we),
    .flow_stat_wr_clk(link.flow_stat_wr_clk), .rx_clk_dly_sel(link.rx_clk_dly_sel),
    .rx_status_clk(link.rx_status_clk));

  always #10 sys_clk = ~sys_clk;

  // The source clock runs at a quarter of the system rate so the status clock has a fixed period.
  always @(posedge sys_clk) #1 src_cnt = src_cnt + 2'h1;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic settle();
    repeat (3) step();
  endtask

  function automatic rx_word_s mkw(input int i, input int b);
    return {i == 0, i == 1, i == 7, i == 4, (i == 7) ? 4'h3 : 4'hF, 32'hC0DE0000 + 32'(b * 256 + i)};
  endfunction

  function automatic rx_word_s link_word(input int b);
    return {link.portid_flag[b], link.pkt_first[b], link.pkt_last[b], link.word_bad[b],
            link.byte_valid[b], link.rd_word[b]};
  endfunction

  task automatic push_n(input int b, input int first, input int n);
    fill_valid[b] = 1'b1;
    for (int i = 0; i < n; i++) begin
      fill_word[b] = mkw(first + i, b);
      step();
    end
    fill_valid[b] = 1'b0;
  endtask

  task automatic op(input logic is_rd, input int b, input logic [ADDR_W-1:0] a,
                    input logic [PORT_W-1:0] p, input logic [STAT_W-1:0] v);
    int n = 0;
    rd_req = is_rd;
    stat_req = !is_rd;
    rd_buf = 1'(b);
    rd_addr = a;
    stat_port = p;
    stat_val = v;
    step();
    rd_req = 1'b0;
    stat_req = 1'b0;
    chk(busy === 1'b1, "request not taken");
    while (rd_done_out !== 1'b1 && n < 20) begin
      step();
      n++;
    end
    chk(n == 6, "answer latency");
    step();
  endtask

  task automatic rdchk(input int b, input logic [ADDR_W-1:0] a, input rx_word_s exp);
    op(1'b1, b, a, 8'h00, 2'h0);
    chk(rd_word_out === exp, "read word");
    chk(link_word(b) === exp, "word on link");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_stream(input int b);
    chk(empty_out[b] === 1'b1, "empty at start");
    push_n(b, 0, FIFO_DEPTH);
    chk(fill_ready_out[b] === 1'b0, "full buffer accepts more");
    settle();
    chk(empty_out[b] === 1'b0, "filled buffer shown empty");
    for (int i = 0; i < FIFO_DEPTH; i++) rdchk(b, 3'h0, mkw(i, b));
    settle();
    chk(empty_out[b] === 1'b1, "drained buffer not empty");
  endtask

  // Offset reads pop only the head, and a read of an empty buffer must leave the word alone.
  task automatic t_peek();
    push_n(0, 1, 3);
    rdchk(0, 3'h2, mkw(3, 0));
    rdchk(0, 3'h0, mkw(2, 0));
    rdchk(0, 3'h0, mkw(3, 0));
    rdchk(0, 3'h0, mkw(3, 0));
  endtask

  task automatic t_empty_kind();
    kind_sel = 2'b10;
    push_n(1, 0, 2);
    settle();
    chk(empty_out[1] === 1'b0, "level two shown empty");
    rdchk(1, 3'h0, mkw(0, 1));
    settle();
    chk(empty_out[1] === 1'b1, "low level not shown");
    kind_sel = 2'b00;
    settle();
    chk(empty_out[1] === 1'b0, "true empty kind wrong");
    rdchk(1, 3'h0, mkw(1, 1));
  endtask

  task automatic t_status();
    int n1 = 0;
    int n3 = 0;
    for (int p = 0; p < PORT_CNT; p++) op(1'b0, 0, 3'h0, 8'(p), (p == 8'hA5) ? 2'h3 : 2'h1);
    send_en = 1'b1;
    repeat (3) @(posedge flow_stat_clk_out);
    for (int k = 0; k < PORT_CNT; k++) begin
      @(posedge flow_stat_clk_out);
      step();
      step();
      n1 += int'(flow_stat_word_out === 2'h1);
      n3 += int'(flow_stat_word_out === 2'h3);
    end
    chk(n3 == 1 && n1 == PORT_CNT - 1, "status scan");
    send_en = 1'b0;
    repeat (3) @(posedge flow_stat_clk_out);
    step();
    chk(flow_stat_word_out === 2'h0, "status sent while disabled");
  endtask

  task automatic phase(output int ph);
    repeat (4) @(posedge flow_stat_clk_out);
    ph = int'($time % 80);
    step();
  endtask

  task automatic t_clock();
    time t0;
    int  ph0, ph;
    @(posedge flow_stat_clk_out);
    t0 = $time;
    @(posedge flow_stat_clk_out);
    chk($time - t0 == 4 * SRC_DIV * 20, "status clock period");
    chk(link.rx_status_clk === flow_stat_clk_out, "status clock on link");
    phase(ph0);
    static_mode = 1'b1;
    dly_en = 1'b1;
    for (int s = 0; s <= DLY_MAX; s++) begin
      dly_sel = 3'(s);
      phase(ph);
      chk(ph == (ph0 + (s + 1) * 20) % 80, "delay tap");
    end
    dly_sel = 3'h7;
    settle();
    chk(link.rx_clk_dly_sel === 3'h6, "delay select not limited");
    static_mode = 1'b0;
    phase(ph);
    chk(link.rx_clk_dly_en === 1'b0 && ph == ph0, "dynamic mode bypass");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    rst_b = 1'b0;
    fill_valid = '0;
    fill_word = '0;
    kind_sel = '0;
    halt = 2'b11;
    src_cnt = 2'h0;
    rd_req = 1'b0;
    rd_buf = 1'b0;
    rd_addr = '0;
    stat_req = 1'b0;
    stat_port = '0;
    stat_val = '0;
    send_en = 1'b0;
    static_mode = 1'b0;
    dly_en = 1'b0;
    dly_sel = '0;
    n_fail = 0;
    checks_done = 0;
    repeat (5) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    t_stream(0);
    t_stream(1);
    t_peek();
    t_empty_kind();
    t_status();
    t_clock();
    complete_run();
  end

  initial begin
    #400000;
    n_fail++;
    $display("unexpected at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule
